/* hw/sync_serial_pkg.sv */
// Shared constants and carriers of the synchronous serial port control block.
// Assumes a host register port with a 12-bit byte offset and 32-bit data.
package sync_serial_pkg;

    // ********************************************************************
    // Register offsets (byte addresses)
    // ********************************************************************
    localparam logic [11:0] CTRL_OFS = 12'h380;
    localparam logic [11:0] BAUD_OFS = 12'h384;
    localparam logic [11:0] TXBUF_OFS = 12'h388;
    localparam logic [11:0] RXBUF_OFS = 12'h38c;

    // ********************************************************************
    // Field positions of the control/status word
    // ********************************************************************
    localparam int EN_BIT = 15;
    localparam int MS_BIT = 14;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0000;

    // Configuration fields, stored while the port is disabled.
    typedef struct packed {
        logic ms;
        logic ben;
        logic pen;
        logic ren;
        logic ten;
        logic po;
        logic ph;
        logic hb;
        logic [3:0] bm;
    } cfg_t;

    // Sticky error flags shown in operation mode.
    typedef struct packed {
        logic be;
        logic pe;
        logic re;
        logic te;
    } err_t;

    // Transfer engine states.
    typedef enum logic {ST_IDLE, ST_XFER} xfer_st_t;

    // Complete state of the port control block.
    typedef struct packed {
        logic en;
        cfg_t cfg;
        err_t err;
        logic [15:0] baud;
        xfer_st_t st;
        logic [15:0] tx_sr;
        logic [15:0] rx_sr;
        logic [15:0] rx_buf;
        logic rx_full;
        logic [4:0] sh_cnt;
        logic [4:0] bit_cnt;
        logic [5:0] tog;
        logic [15:0] bcnt;
        logic clk_lvl;
        logic dout;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic rx_s1;
        logic rx_s2;
        logic rx_d;
        logic [18:0] per;
        logic per_ok;
        logic [3:0] since_rx;
        logic [3:0] post;
        logic [31:0] rdata;
    } port_state_t;

endpackage

/* hw/sync_serial_port_control.sv */
// Control/status word, shift engine and transmit queue of a synchronous
// serial port. Assumes a single-cycle host register port on core_clk_in
// and a serial clock pin that is resolved by the surroundings.
//
// Function
// - Enable bit switches word between config/status.
// - Master drives shift clock, slave receives it.
// - Master select readable and effective always.
// - Busy flag high during a transfer.
// - Baud check disabled never raises baud flag.
// - Baud flag on period beyond twice or half.
// - Phase check enable gates phase errors.
// - Phase flag on data change near sample.
// - Receive check enable gates overrun errors.
// - Receive flag when unread buffer overwritten.
// - Transmit check enable gates underrun errors.
// - Transmit flag when frame starts without data.
// - Polarity sets idle level and leading edge.
// - Phase selects shift and sample edges.
// - Bit order selects LSB or MSB first.
// - Frame length is width field plus one.
// - Low status nibble counts sampled bits.
`timescale 1ns/1ns

// ************************************************************************
// Transmit word queue
// ************************************************************************
module tx_word_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Filling side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    // Draining side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    // Whole queue state; DEPTH must be a power of two for pointer wrap.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t q; // Registered state.
    fifo_state_t n; // Next state.
    logic push; // Accepted write.
    logic pop; // Accepted read.

    assign in_ready_out = (q.cnt != FULL_CNT);
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out = q.mem[q.rp];

    // Pointer and count update for simultaneous push and pop.
    always_comb begin
        n = q;
        push = in_valid_in && in_ready_out;
        pop = out_ready_in && out_valid_out;
        if (push) begin
            n.mem[q.wp] = in_data_in;
            n.wp = q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = q.rp + 1'b1;
        end
        n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule // tx_word_fifo

// ************************************************************************
// Port control top
// ************************************************************************
module sync_serial_port_control
    import sync_serial_pkg::*;
#(
    parameter logic [3:0] GUARD_CYC = 4'h2, // Phase guard half-width in cycles.
    parameter int TXQ_DEPTH = 16
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Host register port.
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic tx_buf_ready_out,
    // Serial link pins.
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe_out,
    input wire logic rx_data_in,
    output logic tx_data_out
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    port_state_t q; // Registered state.
    port_state_t n; // Next state.
    logic q_valid; // Queue holds a word.
    logic [15:0] q_data; // Head word of the queue.
    logic q_pop; // Take the head word.
    logic q_push; // Host writes the transmit buffer.
    logic [4:0] width; // Active frame length.
    logic lead; // Leading clock edge this cycle.
    logic trail; // Trailing clock edge this cycle.
    logic samp; // Receive sampling edge.
    logic shft; // Transmit shifting edge.
    logic load; // Frame begins this cycle.
    logic active; // Engine owns this cycle's edges.
    logic rx_chg; // Synchronised receive data changed.
    logic [17:0] exp_per; // Expected bit time in cycles.
    logic [31:0] rd_mux; // Read data before registering.

    // Bit position of the k-th bit on the line for the chosen order.
    function automatic logic [3:0] bit_idx(input logic msb, input logic [4:0] w,
                                           input logic [4:0] k);
        logic [4:0] r;
        r = msb ? (w - 5'h01 - k) : k;
        return r[3:0];
    endfunction

    // Host writes feed the queue; a full queue is shown on the ready port.
    assign q_push = reg_wr_in && (reg_addr_in == TXBUF_OFS);

    tx_word_fifo #(
        .W(16),
        .DEPTH(TXQ_DEPTH)
    ) u_txq (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(q_push),
        .in_ready_out(tx_buf_ready_out),
        .in_data_in(reg_wdata_in[15:0]),
        .out_valid_out(q_valid),
        .out_ready_in(q_pop),
        .out_data_out(q_data)
    );

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    // Register access, edge finding, shifting and error checks in one place.
    always_comb begin
        n = q;
        q_pop = 1'b0;
        load = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        width = {1'b0, q.cfg.bm} + 5'h01;
        exp_per = {({1'b0, q.baud} + 17'h00001), 1'b0};
        // Two flip-flops before any logic reads a pin.
        n.sclk_s1 = sclk_in;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_d = q.sclk_s2;
        n.rx_s1 = rx_data_in;
        n.rx_s2 = q.rx_s1;
        n.rx_d = q.rx_s2;
        rx_chg = (q.rx_s2 != q.rx_d);
        // Age of the last data change and the window after a sample.
        if (rx_chg) begin
            n.since_rx = '0;
        end else if (q.since_rx != GUARD_CYC) begin
            n.since_rx = q.since_rx + 4'h1;
        end
        if (q.post != '0) begin
            n.post = q.post - 4'h1;
        end
        // Control/status read mux; master select means the same in both.
        if (q.en) begin
            rd_mux = {16'h0000, 1'b1, q.cfg.ms, 1'b0, (q.st == ST_XFER),
                      q.err, 4'h0, q.bit_cnt[3:0]};
        end else begin
            rd_mux = {16'h0000, 1'b0, q.cfg.ms, 2'b00, q.cfg.ben, q.cfg.pen,
                      q.cfg.ren, q.cfg.ten, 1'b0, q.cfg.po, q.cfg.ph, q.cfg.hb, q.cfg.bm};
        end
        case (reg_addr_in)
            CTRL_OFS: rd_mux = rd_mux;
            BAUD_OFS: rd_mux = {16'h0000, q.baud};
            RXBUF_OFS: rd_mux = {16'h0000, q.rx_buf};
            default: rd_mux = '0;
        endcase
        if (reg_rd_in) begin
            n.rdata = rd_mux;
            if (reg_addr_in == RXBUF_OFS) begin
                n.rx_full = 1'b0;
            end
        end
        // Writes; configuration only lands while disabled.
        if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
            n.en = reg_wdata_in[EN_BIT];
            if (!q.en) begin
                n.cfg = {reg_wdata_in[MS_BIT], reg_wdata_in[11:8], reg_wdata_in[6:0]};
            end
        end
        if (reg_wr_in && reg_addr_in == BAUD_OFS && !q.en) begin
            n.baud = reg_wdata_in[15:0];
        end
        // Master makes its own clock; slave watches the pin.
        if (q.cfg.ms) begin
            if (q.st == ST_XFER) begin
                if (q.bcnt == '0) begin
                    n.bcnt = q.baud;
                    n.clk_lvl = ~q.clk_lvl;
                    lead = (q.clk_lvl == q.cfg.po);
                    trail = !lead;
                    n.tog = q.tog + 6'h01;
                end else begin
                    n.bcnt = q.bcnt - 16'h0001;
                end
            end
        end else begin
            lead = (q.sclk_s2 != q.sclk_d) && (q.sclk_d == q.cfg.po);
            trail = (q.sclk_s2 != q.sclk_d) && (q.sclk_d != q.cfg.po);
        end
        samp = q.cfg.ph ? lead : trail;
        shft = q.cfg.ph ? trail : lead;
        // Frame start: master on queued data, slave on its first edge.
        if (q.en && q.st == ST_IDLE) begin
            if (q.cfg.ms) begin
                load = q_valid;
            end else begin
                load = lead;
                if (lead && !q_valid && q.cfg.ten) begin
                    n.err.te = 1'b1;
                end
            end
        end
        if (load) begin
            q_pop = q_valid;
            n.tx_sr = q_valid ? q_data : '0;
            n.st = ST_XFER;
            n.sh_cnt = '0;
            n.bit_cnt = '0;
            n.tog = '0;
            n.bcnt = q.baud;
            n.per_ok = 1'b0;
            // Late phase needs the first bit on the line before any shift.
            if (q.cfg.ph) begin
                n.dout = n.tx_sr[bit_idx(q.cfg.hb, width, 5'h00)];
                n.sh_cnt = 5'h01;
            end
        end
        active = q.en && (q.st == ST_XFER || load);
        if (active && shft && n.sh_cnt < width) begin
            n.dout = n.tx_sr[bit_idx(q.cfg.hb, width, n.sh_cnt)];
            n.sh_cnt = n.sh_cnt + 5'h01;
        end
        // Period between sampling edges, saturating.
        if (q.per != '1) begin
            n.per = q.per + 19'h00001;
        end
        if (active && samp) begin
            n.rx_sr[bit_idx(q.cfg.hb, width, n.bit_cnt)] = q.rx_s2;
            n.bit_cnt = n.bit_cnt + 5'h01;
            n.post = GUARD_CYC;
            n.per = '0;
            n.per_ok = 1'b1;
            if (q.cfg.pen && (rx_chg || q.since_rx < GUARD_CYC)) begin
                n.err.pe = 1'b1;
            end
            // Only a received clock can be off rate.
            if (!q.cfg.ms && q.per_ok && q.cfg.ben &&
                (q.per > {exp_per, 1'b0} || {q.per, 1'b0} < {2'b00, exp_per})) begin
                n.err.be = 1'b1;
            end
            if (n.bit_cnt == width) begin
                n.rx_buf = n.rx_sr;
                if (n.rx_full && q.cfg.ren) begin
                    n.err.re = 1'b1;
                end
                n.rx_full = 1'b1;
                if (!q.cfg.ms) begin
                    n.st = ST_IDLE;
                end
            end
        end
        // A change just after a sample also violates the guard window.
        if (q.en && q.post != '0 && rx_chg && q.cfg.pen) begin
            n.err.pe = 1'b1;
        end
        if (q.cfg.ms && q.st == ST_XFER && n.tog == {width, 1'b0}) begin
            n.st = ST_IDLE;
        end
        // Leaving operation clears flags and parks the clock.
        if (!n.en) begin
            n.err = '0;
            n.st = ST_IDLE;
            n.clk_lvl = n.cfg.po;
        end
    end

    // State register; everything resets to zero, matching the word's reset.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign reg_rdata_out = q.rdata;
    assign sclk_out = q.clk_lvl;
    assign sclk_oe_out = q.cfg.ms;
    assign tx_data_out = q.dout;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_status_busy_read: assert property (reg_rd_in && reg_addr_in == CTRL_OFS && q.en
        |=> reg_rdata_out[12] == $past(q.st == ST_XFER) && reg_rdata_out[15])
        else $error("busy status read mismatch");
    a_master_sel_read: assert property (reg_rd_in && reg_addr_in == CTRL_OFS
        |=> reg_rdata_out[MS_BIT] == $past(q.cfg.ms))
        else $error("master select not readable");
    a_slave_no_drive: assert property (!q.cfg.ms |-> !sclk_oe_out)
        else $error("slave drives the clock pin");
    a_baud_off_quiet: assert property (!q.cfg.ben |-> !q.err.be)
        else $error("baud flag without checking");
    a_phase_off_quiet: assert property (!q.cfg.pen |-> !q.err.pe)
        else $error("phase flag without checking");
    a_rx_off_quiet: assert property (!q.cfg.ren |-> !q.err.re)
        else $error("receive flag without checking");
    a_tx_off_quiet: assert property (!q.cfg.ten |-> !q.err.te)
        else $error("transmit flag without checking");
    a_err_sticky_on: assert property (q.en && $past(q.en) && $past(q.err.re) |-> q.err.re)
        else $error("receive flag dropped while enabled");
    a_err_clear_off: assert property (!q.en |-> q.err == '0)
        else $error("flags not cleared in configuration");
    a_clk_idle_level: assert property (q.cfg.ms && q.st == ST_IDLE |-> sclk_out == q.cfg.po)
        else $error("master clock not at idle level");
    a_count_in_frame: assert property (q.st == ST_XFER |-> q.bit_cnt <= width)
        else $error("bit counter past frame length");
    a_rx_overrun: assert property (q.en && q.cfg.ren && q.rx_full && !reg_rd_in && active && samp
        && !load && !reg_wr_in && q.bit_cnt + 5'h01 == width |=> q.err.re)
        else $error("overrun not flagged");

    c_master_frame: cover property (q.cfg.ms && q.st == ST_XFER ##1 q.st == ST_IDLE);
    c_slave_start: cover property (!q.cfg.ms && load);
    c_rx_error: cover property (!q.err.re ##1 q.err.re);
endmodule // sync_serial_port_control

/* tb/serial_peer_model.sv */
// Behavioural serial peripheral at the far end of the port's link pins.
// Assumes the bench resolves the shared clock pin and arms every frame.
`timescale 1ns/1ns
module serial_peer_model (
    // Link pins as the peripheral sees them.
    input wire logic sclk_in,
    input wire logic tx_in,
    output logic rx_out,
    output logic sclk_drv_out
);
    logic po, ph, msb, late, armed; // Frame settings and activity.
    logic [4:0] w, idx, scnt; // Width, next bit out, bits taken.
    logic [15:0] word, got; // Word sent and word received.
    initial begin
        armed = 1'b0;
        po = 1'b0;
        rx_out = 1'b0;
        sclk_drv_out = 1'b0;
        got = 16'h0000;
    end
    // Puts the next bit on the receive line of the port.
    task automatic drive();
        rx_out = word[msb ? w - 5'h01 - idx : idx];
        idx = idx + 5'h01;
    endtask
    // Loads one frame; with phase 1 and late off the first bit stands before the leading edge.
    task automatic arm(input logic po_i, ph_i, msb_i, late_i, input logic [4:0] w_i,
                       input logic [15:0] word_i);
        {po, ph, msb, late, w, word} = {po_i, ph_i, msb_i, late_i, w_i, word_i};
        idx = 5'h00;
        scnt = 5'h00;
        got = 16'h0000;
        sclk_drv_out = po_i;
        armed <= 1'b1; // Parking the clock above must not count as a frame edge.
        if (ph_i && !late_i) drive();
    endtask
    // Makes a slave-mode frame clock of n bits, 160 ns a bit, idle between frames.
    task automatic gen(input int n);
        #4;
        repeat (n) begin
            #80 sclk_drv_out = ~po;
            #80 sclk_drv_out = po;
        end
    endtask
    // Late mode moves data onto the sampling edge to provoke phase errors.
    always @(sclk_in) begin
        if (armed) begin
            if ((((sclk_in != po) == ph) == late) && idx < w) drive();
            if ((sclk_in != po) == ph) begin
                got[msb ? w - 5'h01 - scnt : scnt] = tx_in;
                scnt = scnt + 5'h01;
                if (scnt == w) begin
                    armed = 1'b0;
                    rx_out = ~rx_out; // Released line must not keep the last bit.
                end
            end
        end
    end
endmodule // serial_peer_model

/* tb/sync_serial_port_control_tb.sv */
// Self-checking bench of the serial port control block and its peer model.
// Assumes the host port answers reads one cycle after the read edge.
`timescale 1ns/1ns
module sync_serial_port_control_tb;
    import sync_serial_pkg::*;
    // ********************************************************************
    // Signals, design and peer
    // ********************************************************************
    logic core_clk_in, rst_n_in, reg_wr_in, reg_rd_in; // Clock, reset, strobes.
    logic [11:0] reg_addr_in; // Register offset.
    logic [31:0] reg_wdata_in, v; // Write data and last read value.
    wire logic [31:0] reg_rdata_out;
    wire logic tx_buf_ready_out, sclk_out, sclk_oe_out, tx_data_out, rx_w, peer_sclk, sclk_w;
    int n_errors = 0, tests_run = 0, cyc = 0;
    // The clock pin level follows whichever side drives it.
    assign sclk_w = sclk_oe_out ? sclk_out : peer_sclk;
    sync_serial_port_control #(.GUARD_CYC(4'h2), .TXQ_DEPTH(16)) DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .tx_buf_ready_out(tx_buf_ready_out),
        .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
        .rx_data_in(rx_w), .tx_data_out(tx_data_out));
    serial_peer_model peer (.sclk_in(sclk_w), .tx_in(tx_data_out), .rx_out(rx_w),
        .sclk_drv_out(peer_sclk));
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic chk(input string what, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // One write strobe; every task starts and ends 1 ns after a rising edge.
    // A spare cycle after the strobe keeps back-to-back writes apart.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        idle(1);
        reg_wr_in = 1'b0;
        idle(1);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        idle(1);
        reg_rd_in = 1'b0;
        idle(1);
        d = reg_rdata_out;
    endtask
    task automatic final_report();
        $display("checks run %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // A hang counts as a mismatch; the whole run needs about 1700 cycles.
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            final_report();
        end
    end
    // ********************************************************************
    // Scenarios
    // ********************************************************************
    initial begin
        rst_n_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 12'h000;
        reg_wdata_in = 32'h0000_0000;
        repeat (3) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        rd(CTRL_OFS, v); chk("ctrl reset", v, 32'h0000_0000);
        rd(12'h7fc, v); chk("unmapped read", v, 32'h0000_0000);
        wr(CTRL_OFS, 32'hffff_7fff);
        rd(CTRL_OFS, v); chk("config readback", v, 32'h0000_4f7f);
        // Queue is filled past its depth, then drained by 2-bit master frames.
        wr(CTRL_OFS, 32'h0000_4001);
        wr(BAUD_OFS, 32'h0000_0001);
        for (int i = 0; i < 17; i++) wr(TXBUF_OFS, i);
        chk("queue full", tx_buf_ready_out, 32'h0);
        wr(CTRL_OFS, 32'h0000_c001);
        idle(8);
        rd(CTRL_OFS, v); chk("master select kept", v & 32'hc000, 32'h0000_c000);
        chk("clock driven", sclk_oe_out, 32'h1);
        idle(300);
        chk("queue drained", tx_buf_ready_out, 32'h1);
        rd(CTRL_OFS, v); chk("no busy no errors", v & 32'h1f00, 32'h0);
        // One 8-bit LSB-first master frame, polarity 0, phase 0.
        wr(CTRL_OFS, 32'h0000_0000);
        wr(BAUD_OFS, 32'h0000_0004);
        // The drained frames left the buffer full; read it so no overrun is pending.
        rd(RXBUF_OFS, v); chk("stale rx buffer", v, 32'h0000_0000);
        wr(CTRL_OFS, 32'h0000_4207);
        wr(TXBUF_OFS, 32'h0000_00a5);
        peer.arm(1'b0, 1'b0, 1'b0, 1'b0, 5'd8, 16'h003c);
        wr(CTRL_OFS, 32'h0000_c207);
        idle(12);
        rd(CTRL_OFS, v); chk("busy in frame", v & 32'h1000, 32'h0000_1000);
        idle(120);
        rd(CTRL_OFS, v); chk("status after frame", v & 32'h1fff, 32'h0000_0008);
        rd(RXBUF_OFS, v); chk("lsb first rx", v, 32'h0000_003c);
        chk("lsb first tx", peer.got, 32'h0000_00a5);
        chk("idle low", sclk_w, 32'h0);
        // Two frames without reading the buffer raise the sticky receive flag.
        wr(TXBUF_OFS, 32'h0000_0011);
        wr(TXBUF_OFS, 32'h0000_0022);
        idle(250);
        rd(CTRL_OFS, v); chk("overrun", v & 32'h0200, 32'h0000_0200);
        wr(CTRL_OFS, 32'h0000_0000);
        rd(CTRL_OFS, v); chk("config kept", v, 32'h0000_4207);
        wr(CTRL_OFS, 32'h0000_c207);
        rd(CTRL_OFS, v); chk("flags cleared", v & 32'h0f00, 32'h0);
        // A 16-bit MSB-first frame, polarity 1, phase 1.
        wr(CTRL_OFS, 32'h0000_0000);
        wr(CTRL_OFS, 32'h0000_407f);
        wr(TXBUF_OFS, 32'h0000_1234);
        peer.arm(1'b1, 1'b1, 1'b1, 1'b0, 5'd16, 16'hbeef);
        wr(CTRL_OFS, 32'h0000_c07f);
        idle(250);
        rd(RXBUF_OFS, v); chk("msb first rx", v, 32'h0000_beef);
        chk("msb first tx", peer.got, 32'h0000_1234);
        chk("idle high", sclk_w, 32'h1);
        // Slave frame with every check but the receive check on: slow clock, late data, empty queue.
        wr(CTRL_OFS, 32'h0000_0000);
        wr(CTRL_OFS, 32'h0000_0d07);
        wr(CTRL_OFS, 32'h0000_8d07);
        chk("clock received", sclk_oe_out, 32'h0);
        peer.arm(1'b0, 1'b0, 1'b0, 1'b1, 5'd8, 16'h005a);
        peer.gen(8);
        idle(10);
        rd(CTRL_OFS, v); chk("slave errors", v & 32'h0f00, 32'h0000_0d00);
        chk("underrun sends zeros", peer.got, 32'h0);
        // The same faults with every check off must leave the flags clear.
        wr(CTRL_OFS, 32'h0000_0000);
        wr(CTRL_OFS, 32'h0000_0007);
        wr(CTRL_OFS, 32'h0000_8007);
        peer.arm(1'b0, 1'b0, 1'b0, 1'b1, 5'd8, 16'h005a);
        peer.gen(8);
        idle(10);
        rd(CTRL_OFS, v); chk("checks off", v & 32'h0f00, 32'h0);
        final_report();
    end
endmodule // sync_serial_port_control_tb
